// ==== hw/cpid_pkg.sv ====
package cpid_pkg;

	// host side key values
	localparam logic [7:0] CPID_KEY_ENTER = 8'h55;
	localparam logic [7:0] CPID_KEY_EXIT = 8'haa;

	// port layout
	localparam logic [15:0] CPID_BASE_RESET = 16'h002e;
	localparam logic [15:0] CPID_DATA_OFFSET = 16'h0001;

	// global indices
	localparam logic [7:0] CPID_IDX_CONFIG_CONTROL = 8'h02;
	localparam logic [7:0] CPID_IDX_RESERVED_A = 8'h03;
	localparam logic [7:0] CPID_IDX_LD_SELECT = 8'h07;
	localparam logic [7:0] CPID_IDX_PART_ID = 8'h20;
	localparam logic [7:0] CPID_IDX_REVISION = 8'h21;
	localparam logic [7:0] CPID_IDX_POWER = 8'h22;
	localparam logic [7:0] CPID_IDX_RESERVED_B = 8'h23;
	localparam logic [7:0] CPID_IDX_OSC = 8'h24;
	localparam logic [7:0] CPID_IDX_BASE_LOW = 8'h26;
	localparam logic [7:0] CPID_IDX_BASE_HIGH = 8'h27;
	localparam logic [7:0] CPID_IDX_NUM_TEST = 8'h29;
	// indices at or above this go to the selected logical device
	localparam logic [7:0] CPID_IDX_LD_FIRST = 8'h30;

	// field positions
	localparam int CPID_SOFT_RESET_BIT = 0;
	localparam int CPID_NUM_SELECT_BIT = 0;

	// reset values
	localparam logic [7:0] CPID_LD_SELECT_RESET = 8'h00;
	localparam logic [7:0] CPID_POWER_RESET = 8'h00;
	localparam logic [7:0] CPID_OSC_RESET = 8'h44;
	localparam logic [7:0] CPID_NUM_TEST_RESET = 8'h00;
	localparam logic [7:0] CPID_READ_ZERO = 8'h00;

	// timing
	localparam int CPID_CLK_MHZ = 100;
	localparam int CPID_BLACKOUT_US = 500;
	localparam int CPID_BLACKOUT_CYCLES = CPID_BLACKOUT_US * CPID_CLK_MHZ;

	typedef enum logic [1:0]
	{
		CPID_RUN = 2'b01,
		CPID_CONFIG = 2'b10
	} cpid_state_t;

	// access forwarded to the logical device register banks
	typedef struct packed
	{
		logic wr;
		logic rd;
		logic numbering_select_bit;
		logic [7:0] number;
		logic [7:0] index;
		logic [7:0] wdata;
	} cpid_ld_req_t;

endpackage

// ==== hw/cpid_config_access.sv ====
// How it works
// - in config state index port at base, data port at base plus one
// - with device selected, index names its register; data port reads or writes it
// - global registers reached through index and data without device selection
// - exit key on config port returns to run state
// - only run and config states; run accepts entry key once blackout ends, unless a bus reset comes in the same cycle
// - writing one to bit 0 of config control soft resets device select and power control and pulses device reset
// - all host accesses ignored for blackout time after power-on reset
// - numbering select bit of test register picks logical device numbering scheme
// - reserved global indices read zero
// - revision index is read only and returns a fixed value
// - entry key in run state enters config state, enabling index and data
// - base address resets to 0x02e and is moved by two byte registers
// - index and data ports act only in config state
// - hard bus reset or power-on gives run state, devices disabled
`timescale 1ns/1ps
`default_nettype none
module cpid_config_access
	import cpid_pkg::*;
#(
	parameter int BLACKOUT_CYCLES = CPID_BLACKOUT_CYCLES,
	parameter logic [7:0] PART_ID = 8'h5a, // arbitrary value
	parameter logic [7:0] REVISION = 8'h01 // arbitrary value
)
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic hard_bus_reset_n,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [15:0] io_addr,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	output logic io_rdata_valid,
	input wire logic [7:0] ld_rdata,
	output cpid_ld_req_t ld_req,
	output logic ld_reset,
	output logic config_mode,
	output logic host_ready,
	output logic [7:0] power_control,
	output logic [7:0] oscillator_control
);

	// counter width follows the parameter so a long blackout cannot wrap
	localparam int BLACKOUT_W = $clog2(BLACKOUT_CYCLES + 1);

	cpid_state_t state;
	cpid_state_t next_state;
	logic [BLACKOUT_W-1:0] blackout_cnt;
	logic [7:0] index;
	logic [7:0] logical_device_select;
	logic [7:0] config_base_low;
	logic [7:0] config_base_high;
	logic [7:0] numbering_test_register;

	wire [15:0] base = {config_base_high, config_base_low};
	wire in_config = (state == CPID_CONFIG);
	wire hit_base = (io_addr == base);
	wire hit_data = (io_addr == base + CPID_DATA_OFFSET);
	wire hard_rst = !hard_bus_reset_n;
	// blackout swallows everything, including keys
	wire open = host_ready;
	wire base_wr = open && io_wr && hit_base;
	wire key_enter = base_wr && !in_config && (io_wdata == CPID_KEY_ENTER);
	wire key_exit = base_wr && in_config && (io_wdata == CPID_KEY_EXIT);
	wire index_wr = base_wr && in_config && !key_exit;
	wire index_rd = open && io_rd && hit_base && in_config;
	wire data_wr = open && io_wr && hit_data && in_config;
	wire data_rd = open && io_rd && hit_data && in_config;
	wire is_ld_idx = (index >= CPID_IDX_LD_FIRST);
	wire glob_wr = data_wr && !is_ld_idx;
	wire soft_rst = glob_wr && (index == CPID_IDX_CONFIG_CONTROL) && io_wdata[CPID_SOFT_RESET_BIT];
	wire [BLACKOUT_W-1:0] blackout_last = BLACKOUT_W'(BLACKOUT_CYCLES - 1);

	logic [7:0] glob_rdata;
	always_comb
	begin
		unique case (index)
			CPID_IDX_LD_SELECT: glob_rdata = logical_device_select;
			CPID_IDX_PART_ID: glob_rdata = PART_ID;
			CPID_IDX_REVISION: glob_rdata = REVISION;
			CPID_IDX_POWER: glob_rdata = power_control;
			CPID_IDX_OSC: glob_rdata = oscillator_control;
			CPID_IDX_BASE_LOW: glob_rdata = config_base_low;
			CPID_IDX_BASE_HIGH: glob_rdata = config_base_high;
			CPID_IDX_NUM_TEST: glob_rdata = numbering_test_register;
			// config control is write only; reserved indices read zero
			default: glob_rdata = CPID_READ_ZERO;
		endcase
	end

	wire [7:0] next_rdata = index_rd ? index : (is_ld_idx ? ld_rdata : glob_rdata);

	// a bus reset outranks a key arriving in the same cycle
	always_comb
	begin
		next_state = state;
		unique case (state)
			CPID_RUN:
				if (key_enter)
					next_state = CPID_CONFIG;
			CPID_CONFIG:
				if (key_exit)
					next_state = CPID_RUN;
			default: next_state = CPID_RUN;
		endcase
		if (hard_rst)
			next_state = CPID_RUN;
	end

	// blackout counter only runs after power-on, not after a bus reset
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			blackout_cnt <= '0;
			host_ready <= 1'b0;
		end
		else if (!host_ready)
		begin
			blackout_cnt <= blackout_cnt + BLACKOUT_W'(1);
			host_ready <= (blackout_cnt == blackout_last);
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			state <= CPID_RUN;
		else
			state <= next_state;
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			index <= 8'h00;
		else if (hard_rst)
			index <= 8'h00;
		else if (index_wr)
			index <= io_wdata;
	end

	// selector and power control take their soft reset values too
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			logical_device_select <= CPID_LD_SELECT_RESET;
			power_control <= CPID_POWER_RESET;
		end
		else if (hard_rst || soft_rst)
		begin
			logical_device_select <= CPID_LD_SELECT_RESET;
			power_control <= CPID_POWER_RESET;
		end
		else if (glob_wr && index == CPID_IDX_LD_SELECT)
			logical_device_select <= io_wdata;
		else if (glob_wr && index == CPID_IDX_POWER)
			power_control <= io_wdata;
	end

	// base address survives bus and soft resets so the bios keeps its port
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			config_base_low <= CPID_BASE_RESET[7:0];
			config_base_high <= CPID_BASE_RESET[15:8];
			oscillator_control <= CPID_OSC_RESET;
			numbering_test_register <= CPID_NUM_TEST_RESET;
		end
		else if (glob_wr)
		begin
			if (index == CPID_IDX_BASE_LOW)
				config_base_low <= io_wdata;
			if (index == CPID_IDX_BASE_HIGH)
				config_base_high <= io_wdata;
			if (index == CPID_IDX_OSC)
				oscillator_control <= io_wdata;
			if (index == CPID_IDX_NUM_TEST)
				numbering_test_register <= io_wdata;
		end
	end

	// read answer holds until the next answered read
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			io_rdata <= 8'h00;
			io_rdata_valid <= 1'b0;
		end
		else
		begin
			io_rdata_valid <= index_rd || data_rd;
			if (index_rd || data_rd)
				io_rdata <= next_rdata;
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ld_req <= '0;
			ld_reset <= 1'b1;
			config_mode <= 1'b0;
		end
		else
		begin
			ld_req.wr <= data_wr && is_ld_idx;
			ld_req.rd <= data_rd && is_ld_idx;
			ld_req.numbering_select_bit <= numbering_test_register[CPID_NUM_SELECT_BIT];
			ld_req.number <= logical_device_select;
			ld_req.index <= index;
			ld_req.wdata <= io_wdata;
			ld_reset <= hard_rst || soft_rst;
			// mirrors the next state so the mode never disagrees with a bus reset
			config_mode <= (next_state == CPID_CONFIG);
		end
	end

endmodule
`default_nettype wire

// ==== tb/cpid_config_access_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpid_chk
	import cpid_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic hard_bus_reset_n,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	input wire logic io_rdata_valid,
	input wire cpid_ld_req_t ld_req,
	input wire logic ld_reset,
	input wire logic config_mode,
	input wire logic host_ready,
	input wire logic [7:0] power_control,
	input wire logic [7:0] oscillator_control
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	a_ready_holds: assert property (host_ready |=> host_ready) else $error("ready dropped");
	a_blackout_quiet: assert property (!host_ready |=> !io_rdata_valid && !ld_req.wr && !ld_req.rd) else $error("blackout");
	a_valid_cause: assert property (io_rdata_valid |-> $past(io_rd)) else $error("answer without read");
	a_ld_write: assert property (ld_req.wr |-> $past(io_wr) && config_mode && ld_req.index >= CPID_IDX_LD_FIRST) else $error("bad ld write");
	a_enter_key: assert property ($rose(config_mode) |-> $past(io_wr) && $past(io_wdata) == CPID_KEY_ENTER) else $error("bad entry");
	a_exit_key: assert property ($fell(config_mode) |-> ($past(io_wr) && $past(io_wdata) == CPID_KEY_EXIT) || !$past(hard_bus_reset_n)) else $error("bad exit");
	a_hard_reset: assert property (!hard_bus_reset_n |=> ld_reset && power_control == CPID_POWER_RESET && !config_mode ##1 !config_mode) else $error("hard reset");
	a_osc_stable: assert property ($changed(oscillator_control) |-> $past(io_wr) && config_mode) else $error("osc changed");
	a_power_stable: assert property ($changed(power_control) |-> $past(io_wr) || !$past(hard_bus_reset_n)) else $error("power changed");
endmodule
bind cpid_config_access cpid_chk u_chk (.*);
`default_nettype wire

// ==== tb/cpid_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpid_host
	import cpid_pkg::*;
(
	input wire logic core_clk,
	output logic io_wr,
	output logic io_rd,
	output logic [15:0] io_addr,
	output logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata,
	input wire logic io_rdata_valid,
	input wire cpid_ld_req_t ld_req,
	output logic [7:0] ld_rdata
);
	// bank stand-in keyed on the index, so a stale index shows
	assign ld_rdata = ld_req.index ^ 8'ha5;
	initial {io_wr, io_rd, io_addr, io_wdata} = '0;
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk);
		io_wr <= 1'b1;
		io_addr <= a;
		io_wdata <= d;
		@(posedge core_clk);
		io_wr <= 1'b0;
		io_addr <= ~a; // released lines must not keep the old value
		io_wdata <= ~d;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
		@(posedge core_clk);
		io_rd <= 1'b1;
		io_addr <= a;
		@(posedge core_clk);
		io_rd <= 1'b0;
		io_addr <= ~a;
		#1;
		d = io_rdata;
		v = io_rdata_valid;
	endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb
	import cpid_pkg::*;
;
	localparam logic [7:0] REV = 8'h3c; // arbitrary value
	localparam logic [7:0] PID = 8'h6b; // arbitrary value
	logic core_clk, resetn, hard_bus_reset_n, io_wr, io_rd, io_rdata_valid, ld_reset, config_mode, host_ready, v, rst_seen, rd_seen;
	logic [15:0] io_addr;
	logic [7:0] io_wdata, io_rdata, ld_rdata, power_control, oscillator_control, d;
	cpid_ld_req_t ld_req, ld_seen;
	int error_cnt, cmp_count;
	cpid_config_access #(.BLACKOUT_CYCLES(16), .PART_ID(PID), .REVISION(REV)) u_cpid_config_access (.*);
	cpid_host u_host (.*);
	initial
	begin
		core_clk = 0;
		forever #5 core_clk = ~core_clk;
	end
	always @(negedge core_clk)
	begin
		if (ld_req.wr) ld_seen <= ld_req;
		if (ld_reset) rst_seen <= 1;
		if (ld_req.rd) rd_seen <= 1;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic conclude;
		if (error_cnt == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic nap;
		@(posedge core_clk);
		#1;
	endtask
	task automatic cfg(input logic [15:0] b, input logic [7:0] i, input logic [7:0] x);
		u_host.wr(b, i);
		u_host.wr(b + 16'h0001, x);
	endtask
	task automatic get(input logic [15:0] b, input logic [7:0] i, input logic [7:0] e);
		u_host.wr(b, i);
		u_host.rd(b + 16'h0001, d, v);
		chk(v, 8'h01);
		chk(d, e);
	endtask
	task automatic t_blackout;
		u_host.wr(16'h002e, CPID_KEY_ENTER);
		u_host.rd(16'h002f, d, v);
		chk(v, 8'h00);
		chk(config_mode, 8'h00);
		for (int n = 0; n < 40 && host_ready !== 1'b1; n++)
			nap;
		chk(host_ready, 8'h01);
	endtask
	task automatic t_keys;
		u_host.wr(16'h002e, 8'h12);
		nap;
		chk(config_mode, 8'h00);
		u_host.wr(16'h002e, CPID_KEY_ENTER);
		nap;
		chk(config_mode, 8'h01);
	endtask
	task automatic t_globals;
		logic [7:0] ix [8] = '{8'h02, 8'h03, 8'h07, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24};
		logic [7:0] ex [8] = '{8'h00, 8'h00, 8'h00, PID, REV, 8'h00, 8'h00, 8'h44};
		foreach (ix[k])
			get(16'h002e, ix[k], ex[k]);
		cfg(16'h002e, CPID_IDX_REVISION, 8'hff);
		get(16'h002e, CPID_IDX_REVISION, REV);
		cfg(16'h002e, CPID_IDX_POWER, 8'ha5);
		get(16'h002e, CPID_IDX_POWER, 8'ha5);
		u_host.rd(16'h002e, d, v);
		chk(v, 8'h01);
		chk(d, CPID_IDX_POWER);
		cfg(16'h002e, CPID_IDX_OSC, 8'h47);
		nap;
		chk(oscillator_control, 8'h47);
	endtask
	task automatic t_ld;
		cfg(16'h002e, CPID_IDX_NUM_TEST, 8'h01);
		cfg(16'h002e, CPID_IDX_LD_SELECT, 8'h03); // selector first, then number
		cfg(16'h002e, 8'h30, 8'h5c);
		nap;
		nap;
		chk(ld_seen.number, 8'h03);
		chk(ld_seen.numbering_select_bit, 8'h01);
		chk(ld_seen.index, 8'h30);
		chk(ld_seen.wdata, 8'h5c);
		rd_seen = 0;
		get(16'h002e, 8'h30, 8'h95);
		nap;
		chk(rd_seen, 8'h01);
	endtask
	task automatic t_soft;
		rst_seen = 0;
		cfg(16'h002e, CPID_IDX_CONFIG_CONTROL, 8'h01);
		nap;
		nap;
		chk(rst_seen, 8'h01);
		chk(power_control, 8'h00);
		get(16'h002e, CPID_IDX_LD_SELECT, 8'h00);
	endtask
	task automatic t_move;
		cfg(16'h002e, CPID_IDX_BASE_LOW, 8'h4e);
		get(16'h004e, CPID_IDX_BASE_LOW, 8'h4e);
		u_host.wr(16'h004e, CPID_KEY_EXIT);
		nap;
		chk(config_mode, 8'h00);
		u_host.rd(16'h004f, d, v);
		chk(v, 8'h00);
		u_host.wr(16'h004e, CPID_KEY_ENTER);
		cfg(16'h004e, CPID_IDX_POWER, 8'h3c);
		@(posedge core_clk) hard_bus_reset_n <= 0;
		@(posedge core_clk) hard_bus_reset_n <= 1;
		nap;
		chk(config_mode, 8'h00);
		chk(power_control, 8'h00);
	endtask
	initial
	begin
		resetn = 0;
		hard_bus_reset_n = 1;
		repeat (16) @(posedge core_clk);
		resetn <= 1;
		t_blackout;
		t_keys;
		t_globals;
		t_ld;
		t_soft;
		t_move;
		conclude;
	end
	initial
	begin
		#20000;
		error_cnt++;
		conclude;
	end
endmodule
`default_nettype wire
